//--- design/dvi_port_irq.sv
/*
  Two-vector interrupt logic for a shared two-word command port, with an
  APB register slave for the host, a core-side command/status interface,
  and a vectored bus request/grant pair toward the host bus.
  Assumes: APB and core on clk_sys; switches, priority plug and grants are
  pins and are synchronised here.
*/
// Decided for this implementation: the APB interface to the registers and the register addresses.
// How it works
// - two vectors: octal ending 0 for input ready, ending 4 for output ready
// - input interrupt needs input enable set and host port request
// - port granted only with no output pending and no core data work
// - input interrupt raised in the cycle the input ready flag sets
// - output interrupt needs output enable and status loaded into the port
// - output load and interrupt held off while core data work is busy
// - output interrupt raised in the cycle the output ready flag sets
// - request level chosen by the priority plug, level five by default
// - only switches one to six shape the vector; eight and ten ignored
// - vector bits 8..3 from switches, bit 2 by logic, bits 1..0 zero
// - host sets request at bit 5; device grants with ready at bit 7
`default_nettype none

module dvi_port_irq (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core side
  input  wire logic              core_busy,
  input  wire logic              out_req,
  input  wire logic [2:0]        out_code,
  input  wire dvi_pkg::dvi_port_t out_info,
  output logic                   out_ack,
  output logic                   cmd_valid,
  output logic      [2:0]        cmd_code,
  output dvi_pkg::dvi_port_t     cmd_data,
  // configuration pins
  input  wire logic [9:0]        switch_bank,
  input  wire logic [1:0]        priority_plug,
  // host bus interrupt
  input  wire logic [3:0]        bus_grant,
  output logic      [3:0]        bus_request,
  output logic      [8:0]        vector_data,
  output logic                   vector_valid
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [15:0] pins_sync;
  logic [9:0]  sw_s;
  logic [1:0]  plug_s;
  logic [3:0]  grant_s;

  dvi_sync #(
    .W (16)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     ({bus_grant, priority_plug, switch_bank}),
    .dout    (pins_sync)
  );

  // split synchronised pins
  assign sw_s    = pins_sync[9:0];
  assign plug_s  = pins_sync[11:10];
  assign grant_s = pins_sync[15:12];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dvi_pkg::dvi_csr_t      in_csr;
  dvi_pkg::dvi_csr_t      out_csr;
  dvi_pkg::dvi_port_t     port;
  dvi_pkg::dvi_vec_state_t vstate;
  dvi_pkg::dvi_csr_t      next_in_csr;
  dvi_pkg::dvi_csr_t      next_out_csr;
  dvi_pkg::dvi_port_t     next_port;
  dvi_pkg::dvi_vec_state_t next_vstate;
  dvi_pkg::dvi_port_t     next_cmd_data;
  logic [31:0]            next_prdata;
  logic                   next_pready;
  logic                   next_pslverr;
  logic                   next_out_ack;
  logic                   next_cmd_valid;
  logic [2:0]             next_cmd_code;
  logic [3:0]             next_bus_request;
  logic [8:0]             next_vector_data;
  logic                   next_vector_valid;

  logic setup;
  logic wr_fire;
  logic wr_in;
  logic wr_out;
  logic grant_in;
  logic load_out;
  logic done_in;
  logic pend_in;
  logic pend_out;
  logic take_in;
  logic take_out;
  logic level_grant;
  logic [3:0] level_onehot;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;
  assign wr_in   = wr_fire & (paddr == dvi_pkg::ADDR_IN_CSR);
  assign wr_out  = wr_fire & (paddr == dvi_pkg::ADDR_OUT_CSR);

  // ----------------------------------------------------------------------
  // port arbitration
  // ----------------------------------------------------------------------
  // grant the port to the host only when it is free
  assign grant_in = in_csr.req & ~in_csr.ready
                  & ~out_csr.ready & ~out_req
                  & ~core_busy;
  // load status only when the port is idle and core work is done
  assign load_out = out_req & ~out_ack & ~out_csr.ready
                  & ~in_csr.ready & ~core_busy;
  // host hands the command over by dropping its request
  assign done_in  = in_csr.ready & wr_in & ~pwdata[dvi_pkg::BIT_REQ];

  // ----------------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------------
  always_comb begin
    next_in_csr    = in_csr;
    next_out_csr   = out_csr;
    next_port      = port;
    next_out_ack   = load_out;
    next_cmd_valid = done_in;
    next_cmd_code  = in_csr.cmd;
    next_cmd_data  = port;
    // host writes of the input byte
    if (wr_in) begin
      next_in_csr.ien = pwdata[dvi_pkg::BIT_IEN];
      next_in_csr.req = pwdata[dvi_pkg::BIT_REQ];
      next_in_csr.cmd = pwdata[2:0];
    end
    // host writes of the output byte; writing zero clears ready
    if (wr_out) begin
      next_out_csr.ien = pwdata[dvi_pkg::BIT_IEN];
      if (!pwdata[dvi_pkg::BIT_READY]) begin
        next_out_csr.ready = 1'b0;
      end
    end
    // host writes of the data port
    if (wr_fire && paddr == dvi_pkg::ADDR_PORT_LO) begin
      next_port.lo = pwdata[15:0];
    end
    if (wr_fire && paddr == dvi_pkg::ADDR_PORT_HI) begin
      next_port.hi = pwdata[15:0];
    end
    // command consumed, port released
    if (done_in) begin
      next_in_csr.ready = 1'b0;
    end
    // device grants the port to the host
    if (grant_in) begin
      next_in_csr.ready = 1'b1;
    end
    // device presents status; wins over host port writes
    if (load_out) begin
      next_port          = out_info;
      next_out_csr.cmd   = out_code;
      next_out_csr.ready = 1'b1;
    end
    next_in_csr.rsvd  = 2'h0;
    next_out_csr.rsvd = 2'h0;
    next_out_csr.req  = 1'b0;
  end

  // ----------------------------------------------------------------------
  // apb answer: ready in the first access cycle
  // ----------------------------------------------------------------------
  always_comb begin
    next_pready  = setup;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        dvi_pkg::ADDR_IN_CSR:  next_prdata = {24'h00_0000, in_csr};
        dvi_pkg::ADDR_OUT_CSR: next_prdata = {24'h00_0000, out_csr};
        dvi_pkg::ADDR_PORT_LO: next_prdata = {16'h0000, port.lo};
        dvi_pkg::ADDR_PORT_HI: next_prdata = {16'h0000, port.hi};
        default:               next_pslverr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // interrupt request holders
  // ----------------------------------------------------------------------
  dvi_irq_chan u_chan_in (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .raise   (grant_in & in_csr.ien),
    .take    (take_in),
    .pending (pend_in)
  );

  dvi_irq_chan u_chan_out (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .raise   (load_out & out_csr.ien),
    .take    (take_out),
    .pending (pend_out)
  );

  // ----------------------------------------------------------------------
  // request level and grant
  // ----------------------------------------------------------------------
  // one-hot request line chosen by the plug
  always_comb begin
    level_onehot = 4'h0;
    level_onehot[plug_s] = 1'b1;
  end

  assign level_grant = grant_s[plug_s];
  // input vector served first when both are pending
  assign take_in  = (vstate == dvi_pkg::VS_IDLE) & level_grant & pend_in;
  assign take_out = (vstate == dvi_pkg::VS_IDLE) & level_grant & pend_out & ~pend_in;

  // vector sequencing
  always_comb begin
    next_vstate       = vstate;
    next_vector_valid = 1'b0;
    next_vector_data  = vector_data;
    next_bus_request  = 4'h0;
    case (vstate)
      dvi_pkg::VS_IDLE: begin
        if (take_in || take_out) begin
          next_vector_valid = 1'b1;
          next_vector_data  = {sw_s[dvi_pkg::VEC_SW_N-1:0],
                               take_in ? dvi_pkg::VEC_LOW_IN
                                       : dvi_pkg::VEC_LOW_OUT};
          next_vstate       = dvi_pkg::VS_RELEASE;
        end else if (pend_in || pend_out) begin
          next_bus_request = level_onehot;
        end
      end
      dvi_pkg::VS_RELEASE: begin
        // wait for the grant to fall before asking again
        if (!level_grant) begin
          next_vstate = dvi_pkg::VS_IDLE;
        end
      end
      default: begin
        next_vstate = dvi_pkg::VS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      in_csr       <= dvi_pkg::CSR_RST;
      out_csr      <= dvi_pkg::CSR_RST;
      port         <= {dvi_pkg::PORT_RST, dvi_pkg::PORT_RST};
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      out_ack      <= 1'b0;
      cmd_valid    <= 1'b0;
      cmd_code     <= 3'h0;
      cmd_data     <= {dvi_pkg::PORT_RST, dvi_pkg::PORT_RST};
      vstate       <= dvi_pkg::VS_IDLE;
      bus_request  <= 4'h0;
      vector_data  <= dvi_pkg::VEC_RST;
      vector_valid <= 1'b0;
    end else begin
      in_csr       <= next_in_csr;
      out_csr      <= next_out_csr;
      port         <= next_port;
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
      out_ack      <= next_out_ack;
      cmd_valid    <= next_cmd_valid;
      cmd_code     <= next_cmd_code;
      cmd_data     <= next_cmd_data;
      vstate       <= next_vstate;
      bus_request  <= next_bus_request;
      vector_data  <= next_vector_data;
      vector_valid <= next_vector_valid;
    end
  end

endmodule // dvi_port_irq

`default_nettype wire

//--- design/dvi_pkg.sv
/*
  Shared constants and types for the two-vector port interrupt logic:
  register offsets, field positions, reset values, vector codes and carriers.
  Assumes nothing of its surroundings; used by the top design file and the bench.
*/
`default_nettype none

package dvi_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets on the register bus
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_IN_CSR  = 12'h000; // input register byte
  localparam logic [11:0] ADDR_OUT_CSR = 12'h004; // output register byte
  localparam logic [11:0] ADDR_PORT_LO = 12'h008; // data port, first word
  localparam logic [11:0] ADDR_PORT_HI = 12'h00c; // data port, second word

  // ----------------------------------------------------------------------
  // field positions inside a control byte
  // ----------------------------------------------------------------------
  localparam int BIT_REQ   = 5; // input request flag
  localparam int BIT_IEN   = 6; // interrupt enable
  localparam int BIT_READY = 7; // ready flag
  localparam int CSR_W     = 8;
  localparam int PORT_W    = 16;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CSR_RST  = 8'h00;
  localparam logic [15:0] PORT_RST = 16'h0000;
  localparam logic [8:0]  VEC_RST  = 9'h000;

  // ----------------------------------------------------------------------
  // vector layout and bus request levels
  // ----------------------------------------------------------------------
  localparam int          VEC_W        = 9;
  localparam int          VEC_SW_N     = 6;      // switches 1..6 -> bits 3..8
  localparam int          SW_BANK_N    = 10;
  localparam logic [2:0]  VEC_LOW_IN   = 3'h0;   // vector ending in octal 0
  localparam logic [2:0]  VEC_LOW_OUT  = 3'h4;   // vector ending in octal 4
  localparam int          LEVEL_N      = 4;      // request levels four..seven
  localparam logic [1:0]  LEVEL_DEFAULT = 2'h1;  // bus_request_level_five

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       ready;
    logic       ien;
    logic       req;
    logic [1:0] rsvd;
    logic [2:0] cmd;
  } dvi_csr_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } dvi_port_t;

  typedef enum {
    VS_IDLE,
    VS_RELEASE
  } dvi_vec_state_t;

endpackage : dvi_pkg

`default_nettype wire

//--- design/dvi_sync.sv
/*
  Two-flop synchroniser for a group of pin-level inputs.
  Assumes the inputs change slowly against clk_sys; the first stage feeds
  only the second.
*/
`default_nettype none

module dvi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;

  // stage inputs
  always_comb begin
    next_meta = din;
    next_dout = meta;
  end

  // two stages
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule // dvi_sync

`default_nettype wire

//--- design/dvi_irq_chan.sv
/*
  One interrupt request holder: raised by an event, held until the bus
  grant takes it. Assumes raise and take come from logic on clk_sys.
*/
`default_nettype none

module dvi_irq_chan (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic raise,
  input  wire logic take,
  output logic      pending
);

  logic next_pending;

  // raise wins over a take in the same cycle
  always_comb begin
    next_pending = raise | (pending & ~take);
  end

  // request flop
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

endmodule // dvi_irq_chan

`default_nettype wire

//--- tb/dvi_monitor.sv
/*
  Checker for the two-vector port interrupt logic, bound to its top.
  Assumes switches and plug stay still while an interrupt request is live.
*/
`default_nettype none

module dvi_monitor (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       core_busy,
  input wire logic       out_ack,
  input wire logic       cmd_valid,
  input wire logic [9:0] switch_bank,
  input wire logic [1:0] priority_plug,
  input wire logic [3:0] bus_grant,
  input wire logic [3:0] bus_request,
  input wire logic [8:0] vector_data,
  input wire logic       vector_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic any_grant;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // any grant pin high, for the grant-to-vector delay
  assign any_grant = |bus_grant;

  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer after setup cycle");
  AST_VEC_LOW: assert property (vector_valid |-> vector_data[1:0] == 2'h0)
    else $error("vector low bits not zero");
  AST_VEC_SW: assert property (vector_valid |-> vector_data[8:3] == switch_bank[5:0])
    else $error("vector high bits differ from switches");
  AST_VEC_DROP: assert property (vector_valid |-> bus_request == 4'h0)
    else $error("request not dropped with vector");
  AST_VEC_GRANT: assert property (vector_valid |-> $past(any_grant, 3))
    else $error("vector without earlier grant");
  AST_VEC_PULSE: assert property (vector_valid |=> !vector_valid)
    else $error("vector valid longer than one cycle");
  AST_REQ_ONEHOT: assert property ($onehot0(bus_request))
    else $error("more than one request level");
  AST_REQ_LEVEL: assert property (bus_request != 4'h0 |-> bus_request[priority_plug])
    else $error("request on wrong level");
  AST_REQ_HOLD: assert property ($fell(bus_request != 4'h0) |-> vector_valid)
    else $error("request dropped without grant");
  AST_ACK_IDLE: assert property (out_ack |-> !$past(core_busy))
    else $error("status loaded while core busy");
  AST_ACK_PULSE: assert property (out_ack |=> !out_ack)
    else $error("load ack longer than one cycle");
  AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
    else $error("command valid longer than one cycle");

  // main scenarios
  COV_IN: cover property (vector_valid && !vector_data[2]);
  COV_OUT: cover property (vector_valid && vector_data[2]);
  COV_ACK: cover property (out_ack);
  COV_CMD: cover property (cmd_valid);
endmodule // dvi_monitor

bind dvi_port_irq dvi_monitor u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pready(pready), .core_busy(core_busy), .out_ack(out_ack), .cmd_valid(cmd_valid),
  .switch_bank(switch_bank), .priority_plug(priority_plug), .bus_grant(bus_grant),
  .bus_request(bus_request), .vector_data(vector_data), .vector_valid(vector_valid)
);

`default_nettype wire

//--- tb/dvi_host_model.sv
/*
  Host bus grant model: grants a request after a set delay and holds the
  grant until the vector is on the bus. Assumes one request level at a time.
*/
`default_nettype none

module dvi_host_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [3:0] bus_request,
  input  wire logic       vector_valid,
  input  wire logic [7:0] delay,
  output logic      [3:0] bus_grant
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] wait_cnt;

  // grant after the delay, withdraw once the vector is taken
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_grant <= 4'h0;
      wait_cnt  <= 8'h00;
    end else if (vector_valid) begin
      bus_grant <= 4'h0;
    end else if (bus_request != 4'h0 && bus_grant == 4'h0) begin
      if (wait_cnt >= delay) begin
        bus_grant <= bus_request;
        wait_cnt  <= 8'h00;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule // dvi_host_model

`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench for the port interrupt logic: APB tasks, core side
  stimulus and a host grant model. Assumes the design package is compiled.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic [11:0]        paddr = 12'h000;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic               pready, pslverr, err, out_ack, cmd_valid, vector_valid;
  logic               core_busy = 1'b0;
  logic               out_req = 1'b0;
  logic [2:0]         out_code = 3'h0, cmd_code;
  dvi_pkg::dvi_port_t out_info = '0, cmd_data;
  logic [9:0]         sw = 10'h000;
  logic [1:0]         plug = 2'h1;
  logic [3:0]         bus_grant, bus_request, lvl;
  logic [8:0]         vector_data;
  logic [7:0]         dly = 8'h00;
  logic [34:0]        cmd_seen;
  int                 fails = 0, checks = 0, cyc = 0, vec_n = 0, ack_n = 0, cmd_n = 0;

  always #4 clk_sys = ~clk_sys;

  dvi_port_irq DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_busy(core_busy), .out_req(out_req), .out_code(out_code), .out_info(out_info),
    .out_ack(out_ack), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .switch_bank(sw), .priority_plug(plug), .bus_grant(bus_grant),
    .bus_request(bus_request), .vector_data(vector_data), .vector_valid(vector_valid));

  dvi_host_model u_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_request(bus_request),
    .vector_valid(vector_valid), .delay(dly), .bus_grant(bus_grant));

  // record output events, cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (vector_valid === 1'b1) vec_n <= vec_n + 1;
    if (out_ack === 1'b1) ack_n <= ack_n + 1;
    if (cmd_valid === 1'b1) cmd_n <= cmd_n + 1;
    if (cmd_valid === 1'b1) cmd_seen <= {cmd_code, cmd_data};
    if (bus_request != 4'h0) lvl <= bus_request;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, e});
  endtask

  task automatic wait_for(ref int c, input int t);
    for (int i = 0; i < 400 && c < t; i++) @(posedge clk_sys);
  endtask

  // one input command, core busy at first
  task automatic in_cmd(input logic ien, input logic [2:0] cmd, input logic [31:0] d);
    int v;
    int c;
    v = vec_n;
    c = cmd_n;
    core_busy <= 1'b1;
    // command code travels with the request; the device reports the held code
    apb(12'h000, 1'b1, {25'h0, ien, 3'h4, cmd});
    repeat (8) @(posedge clk_sys);
    chk_rd(12'h000, {25'h0, ien, 3'h4, cmd}, 1'b0);
    core_busy <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk_rd(12'h000, {24'h0, 1'b1, ien, 3'h4, cmd}, 1'b0);
    wait_for(vec_n, v + 1);
    chk(vec_n, v + ien);
    if (ien) begin
      chk({23'h0, vector_data}, {23'h0, sw[5:0], 3'h0});
      chk({28'h0, lvl}, 32'h1 << plug);
    end
    apb(12'h008, 1'b1, {16'h0, d[15:0]});
    apb(12'h00c, 1'b1, {16'h0, d[31:16]});
    apb(12'h000, 1'b1, {29'h0, cmd});
    wait_for(cmd_n, c + 1);
    chk({29'h0, cmd_seen[34:32]}, {29'h0, cmd});
    chk(cmd_seen[31:0], d);
  endtask

  task automatic final_report();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) chk_rd(12'(i * 4), 32'h0, i == 4);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      plug <= 2'(p);
      sw   <= {4'hf, 6'h2b ^ 6'(p * 9)};
      dly  <= 8'(p * 5);
      in_cmd(1'b1, 3'(p), 32'hc0de_0000 + p);
      $display("test input level %0d done", p);
    end
    in_cmd(1'b0, 3'h7, 32'h0bad_f00d);
    $display("test input disabled done");
    apb(12'h004, 1'b1, 32'h40);
    core_busy <= 1'b1;
    out_req   <= 1'b1;
    out_code  <= 3'h5;
    out_info  <= 32'h1234_5678;
    repeat (20) @(posedge clk_sys);
    chk(ack_n, 0);
    core_busy <= 1'b0;
    wait_for(ack_n, 1);
    out_req <= 1'b0;
    // four enabled input vectors so far, then this output vector
    wait_for(vec_n, 5);
    chk(vec_n, 5);
    chk({23'h0, vector_data}, {23'h0, sw[5:0], 3'h4});
    chk_rd(12'h004, 32'hc5, 1'b0);
    chk_rd(12'h008, 32'h5678, 1'b0);
    chk_rd(12'h00c, 32'h1234, 1'b0);
    apb(12'h000, 1'b1, 32'h20);
    repeat (8) @(posedge clk_sys);
    chk_rd(12'h000, 32'h20, 1'b0);
    apb(12'h004, 1'b1, 32'h40);
    repeat (4) @(posedge clk_sys);
    chk_rd(12'h000, 32'ha0, 1'b0);
    apb(12'h000, 1'b1, 32'h0);
    wait_for(cmd_n, 6);
    chk(cmd_n, 6);
    $display("test output status done");
    final_report();
  end
endmodule // testbench

`default_nettype wire
